// ==== logic/selog_pkg.sv ====
// Package of constants and types for the scan edge and latch logic
package selog_pkg;
    localparam int IMG_W   = 64;   // Image points held by the block
    localparam int IDX_W   = 6;    // Width of an image point index
    localparam int WORD_W  = 16;   // Memory word width
    localparam int BSEL_W  = 5;    // Bit selector width (0..31 offered)
    localparam int WORDS   = 16;   // Memory words held by the block
    localparam int WADR_W  = 4;
    localparam int OUT_W   = 32;   // Physical outputs
    localparam int OIDX_W  = 5;
    localparam logic [IMG_W-1:0]  IMG_RST  = '0;
    localparam logic [WORD_W-1:0] WORD_RST = '0;
    localparam logic [OUT_W-1:0]  OUT_RST  = '0;
    localparam logic [BSEL_W-1:0] BSEL_MAX = 5'h0f;

    // Operation applied in a scan
    typedef enum logic [2:0] {
        SELOG_OP_NONE,
        SELOG_OP_SET,
        SELOG_OP_RST,
        SELOG_OP_BSET,
        SELOG_OP_BCLR
    } selog_op_t;
endpackage

// ==== logic/selog_edge.sv ====
// Per-point edge detector, one scan of history
`timescale 1ns/1ps
module selog_edge
    import selog_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             scan,
    input  wire logic [IMG_W-1:0] img,
    output logic      [IMG_W-1:0] rise,
    output logic      [IMG_W-1:0] fall
);
    typedef struct packed {
        logic [IMG_W-1:0] prev;
        logic [IMG_W-1:0] rise;
        logic [IMG_W-1:0] fall;
        logic             primed;
    } selog_edge_st_t;

    selog_edge_st_t st_r;
    selog_edge_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (scan)
        begin
            // Pulses last until the next scan tick
            if (st_r.primed)
            begin
                st_nxt.rise = img & ~st_r.prev;
                st_nxt.fall = ~img & st_r.prev;
            end
            else
            begin
                // A point already on at reset must not look like an edge
                st_nxt.rise = IMG_RST;
                st_nxt.fall = IMG_RST;
            end
            st_nxt.prev   = img;
            st_nxt.primed = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // History cleared; the next scan only refills it
            st_r <= '{prev: IMG_RST, rise: IMG_RST, fall: IMG_RST,
                      primed: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.rise;
    assign fall = st_r.fall;
endmodule

// ==== logic/selog_top.sv ====
// Scan based edge contacts, latches, bit set and clear, output pause
// Operation
// - Falling-edge OR contact closes one scan after on-to-off, ORed with rung
// - Rising-edge AND contact closes one scan after off-to-on, ANDed with rung
// - Falling-edge AND contact closes one scan after on-to-off, ANDed
// - Latch set drives target point on while rung true
// - Set point stays on after rung drops
// - Optional end operand sets every point in inclusive range
// - Latch reset drives point or inclusive range off
// - Reset point stays off until something turns it on
// - Latch set ignores input points owned by input modules
// - Bit set turns on one bit of a word, held
// - Bit clear turns off one bit, other bits unchanged, held
// - Output pause forces range of physical outputs off
// - During pause image keeps updating, only transfer suppressed
// - Edges compare current scan image with previous scan
`timescale 1ns/1ps
module selog_top
    import selog_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              SCAN_TICK,
    input  wire logic [IMG_W-1:0]  IMG_IN,
    input  wire logic [IMG_W-1:0]  INPUT_OWNED,
    input  wire logic              RUNG_IN,
    input  wire logic [IDX_W-1:0]  EDGE_IDX,
    output logic                   OR_FALLING_EDGE_CONTACT,
    output logic                   AND_RISING_EDGE_CONTACT,
    output logic                   AND_FALLING_EDGE_CONTACT,
    input  wire logic              OP_VALID,
    input  wire selog_op_t         OP_CODE,
    input  wire logic              OP_RUNG,
    input  wire logic [IDX_W-1:0]  OP_START,
    input  wire logic              OP_HAS_END,
    input  wire logic [IDX_W-1:0]  OP_END,
    input  wire logic [WADR_W-1:0] OP_WORD,
    input  wire logic [BSEL_W-1:0] OP_BIT,
    output logic [IMG_W-1:0]       LATCH_IMG,
    output logic [WORD_W*WORDS-1:0] WORD_MEM,
    input  wire logic [OUT_W-1:0]  OUT_IMG,
    input  wire logic              PAUSE_RUNG,
    input  wire logic [OIDX_W-1:0] PAUSE_START,
    input  wire logic [OIDX_W-1:0] PAUSE_END,
    output logic [OUT_W-1:0]       PHYS_OUT
);
    typedef struct packed {
        logic [IMG_W-1:0]             latch;
        logic [WORDS-1:0][WORD_W-1:0] mem;
        logic [OUT_W-1:0]             phys;
    } selog_st_t;

    selog_st_t st_r;
    selog_st_t st_nxt;

    logic [IMG_W-1:0]  rise;
    logic [IMG_W-1:0]  fall;
    logic [IMG_W-1:0]  op_mask;
    logic [IMG_W-1:0]  set_mask;
    logic [IDX_W-1:0]  op_last;
    logic [WORD_W-1:0] word_bit;
    logic [OUT_W-1:0]  pause_mask;
    logic [OUT_W-1:0]  phys_load;
    logic              sel_rise;
    logic              sel_fall;
    logic              do_set;
    logic              do_rst;
    logic              do_bset;
    logic              do_bclr;

    // Inclusive index range mask; a lone point when no end is given
    function automatic logic [IMG_W-1:0] range_mask(
        input logic [IDX_W-1:0] lo,
        input logic [IDX_W-1:0] hi
    );
        logic [IMG_W-1:0] m;
        m = '0;
        for (int i = 0; i < IMG_W; i++)
        begin
            m[i] = (IDX_W'(i) >= lo) && (IDX_W'(i) <= hi);
        end
        return m;
    endfunction

    // One-hot bit of a word; selectors past the top bit write nothing
    function automatic logic [WORD_W-1:0] bit_mask(
        input logic [BSEL_W-1:0] sel
    );
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < WORD_W; i++)
        begin
            m[i] = (sel <= BSEL_MAX) && (BSEL_W'(i) == sel);
        end
        return m;
    endfunction

    selog_edge u_edge (
        .clk  (CLK),
        .rst  (SYS_RST),
        .scan (SCAN_TICK),
        .img  (IMG_IN),
        .rise (rise),
        .fall (fall)
    );

    // The watched point is picked once and shared by the three contacts
    assign sel_rise = rise[EDGE_IDX];
    assign sel_fall = fall[EDGE_IDX];

    // Contacts are combinational with the rung; pulse width is one scan
    assign OR_FALLING_EDGE_CONTACT  = RUNG_IN | sel_fall;
    assign AND_RISING_EDGE_CONTACT  = RUNG_IN & sel_rise;
    assign AND_FALLING_EDGE_CONTACT = RUNG_IN & sel_fall;

    // A range runs from start to end; without an end it is a lone point
    assign op_last = OP_HAS_END ? OP_END : OP_START;

    always_comb
    begin
        op_mask = range_mask(OP_START, op_last);
    end

    // Input-owned points are left to the input scan
    assign set_mask = op_mask & ~INPUT_OWNED;
    assign word_bit = bit_mask(OP_BIT);

    genvar g;
    generate
        for (g = 0; g < OUT_W; g++)
        begin : g_pause
            assign pause_mask[g] = PAUSE_RUNG &&
                (OIDX_W'(g) >= PAUSE_START) && (OIDX_W'(g) <= PAUSE_END);
        end
    endgenerate

    // Image is untouched by pause; only the transfer is blanked
    assign phys_load = OUT_IMG & ~pause_mask;

    // Operation decode; a low rung or an idle slot leaves the latch and word state alone
    always_comb
    begin
        do_set  = 1'b0;
        do_rst  = 1'b0;
        do_bset = 1'b0;
        do_bclr = 1'b0;
        if (OP_VALID && OP_RUNG)
        begin
            unique case (OP_CODE)
                SELOG_OP_SET:
                begin
                    do_set = 1'b1;
                end
                SELOG_OP_RST:
                begin
                    do_rst = 1'b1;
                end
                SELOG_OP_BSET:
                begin
                    do_bset = 1'b1;
                end
                SELOG_OP_BCLR:
                begin
                    do_bclr = 1'b1;
                end
                SELOG_OP_NONE:
                begin
                end
                default:
                begin
                end
            endcase
        end
    end

    // Nothing below needs the rung to stay up: set and reset both hold
    always_comb
    begin
        st_nxt = st_r;
        if (do_set)
        begin
            st_nxt.latch = st_r.latch | set_mask;
        end
        if (do_rst)
        begin
            st_nxt.latch = st_r.latch & ~op_mask;
        end
        if (do_bset)
        begin
            st_nxt.mem[OP_WORD] = st_r.mem[OP_WORD] | word_bit;
        end
        if (do_bclr)
        begin
            st_nxt.mem[OP_WORD] = st_r.mem[OP_WORD] & ~word_bit;
        end
        // Loaded only at the scan tick, as the output transfer would be
        if (SCAN_TICK)
        begin
            st_nxt.phys = phys_load;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st_r.latch <= IMG_RST;
            st_r.mem   <= {WORDS{WORD_RST}};
            st_r.phys  <= OUT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign LATCH_IMG = st_r.latch;
    assign WORD_MEM  = st_r.mem;
    assign PHYS_OUT  = st_r.phys;
endmodule

// ==== tb/selog_chk_sva.sv ====
// Port assertions for the scan edge and latch block
`timescale 1ns/1ps
module selog_chk
    import selog_pkg::*;
(
    input wire logic             CLK,
    input wire logic             SYS_RST,
    input wire logic             SCAN_TICK,
    input wire logic             RUNG_IN,
    input wire logic [IDX_W-1:0] EDGE_IDX,
    input wire logic             OR_FALLING_EDGE_CONTACT,
    input wire logic             AND_RISING_EDGE_CONTACT,
    input wire logic             AND_FALLING_EDGE_CONTACT,
    input wire logic             OP_VALID,
    input wire logic             OP_RUNG,
    input wire selog_op_t        OP_CODE,
    input wire logic [IMG_W-1:0] INPUT_OWNED,
    input wire logic [IMG_W-1:0] LATCH_IMG,
    input wire logic             PAUSE_RUNG,
    input wire logic [OUT_W-1:0] OUT_IMG,
    input wire logic [OUT_W-1:0] PHYS_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire logic go = OP_VALID && OP_RUNG;
    a_rise_rung: assert property (
        AND_RISING_EDGE_CONTACT |-> RUNG_IN) else $error("rise no rung");
    a_fall_rung: assert property (
        AND_FALLING_EDGE_CONTACT |-> RUNG_IN) else $error("fall no rung");
    a_fall_or: assert property (
        AND_FALLING_EDGE_CONTACT |-> OR_FALLING_EDGE_CONTACT)
        else $error("or contact open on fall");
    a_edge_hold: assert property (
        !$past(SYS_RST) && !$past(SCAN_TICK)
        && $stable(RUNG_IN) && $stable(EDGE_IDX)
        |-> $stable(AND_FALLING_EDGE_CONTACT)) else $error("pulse moved");
    a_set_cause: assert property (
        |(LATCH_IMG & ~$past(LATCH_IMG))
        |-> $past(go && OP_CODE == SELOG_OP_SET))
        else $error("point on without set");
    a_clr_cause: assert property (
        |($past(LATCH_IMG) & ~LATCH_IMG)
        |-> $past(go && OP_CODE == SELOG_OP_RST))
        else $error("point off without reset");
    a_owned_kept: assert property (
        (LATCH_IMG & ~$past(LATCH_IMG) & $past(INPUT_OWNED)) == '0)
        else $error("owned point set");
    a_pause_blank: assert property (
        $past(SCAN_TICK) |-> (PHYS_OUT & ~$past(OUT_IMG)) == '0)
        else $error("output on without image");
    a_pass_thru: assert property (
        !$past(SYS_RST) && $past(SCAN_TICK) && !$past(PAUSE_RUNG)
        |-> PHYS_OUT == $past(OUT_IMG)) else $error("image not passed");
endmodule

// ==== tb/selog_outmod.sv ====
// Output module model fed from the physical output lines
`timescale 1ns/1ps
module selog_outmod
    import selog_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [OUT_W-1:0] drive,
    output logic      [OUT_W-1:0] field
);
    // One clock of card delay, so a blanked line shows one cycle late
    always_ff @(posedge clk)
    begin
        field <= drive;
    end
endmodule

// ==== tb/selog_top_tb.sv ====
// Self-checking bench for the scan edge and latch block
`timescale 1ns/1ps
module selog_top_tb
    import selog_pkg::*;
    ;
    logic CLK = 0, SYS_RST = 1, SCAN_TICK = 0, RUNG_IN = 0, OP_VALID = 0;
    logic OP_RUNG = 0, OP_HAS_END = 0, PAUSE_RUNG = 0;
    logic [IMG_W-1:0] IMG_IN = '0, INPUT_OWNED = '0, LATCH_IMG;
    logic [IDX_W-1:0] EDGE_IDX = 6'h03, OP_START = '0, OP_END = '0;
    selog_op_t OP_CODE = SELOG_OP_NONE;
    logic [WADR_W-1:0] OP_WORD = '0;
    logic [BSEL_W-1:0] OP_BIT = '0;
    logic [OUT_W-1:0] OUT_IMG = '0, PHYS_OUT, field;
    logic [OIDX_W-1:0] PAUSE_START = '0, PAUSE_END = '0;
    logic OR_FALLING_EDGE_CONTACT, AND_RISING_EDGE_CONTACT;
    logic AND_FALLING_EDGE_CONTACT;
    logic [WORD_W*WORDS-1:0] WORD_MEM;
    int errors = 0, n_tests = 0;
    selog_top DUT (
        .CLK                      (CLK),
        .SYS_RST                  (SYS_RST),
        .SCAN_TICK                (SCAN_TICK),
        .IMG_IN                   (IMG_IN),
        .INPUT_OWNED              (INPUT_OWNED),
        .RUNG_IN                  (RUNG_IN),
        .EDGE_IDX                 (EDGE_IDX),
        .OR_FALLING_EDGE_CONTACT  (OR_FALLING_EDGE_CONTACT),
        .AND_RISING_EDGE_CONTACT  (AND_RISING_EDGE_CONTACT),
        .AND_FALLING_EDGE_CONTACT (AND_FALLING_EDGE_CONTACT),
        .OP_VALID                 (OP_VALID),
        .OP_CODE                  (OP_CODE),
        .OP_RUNG                  (OP_RUNG),
        .OP_START                 (OP_START),
        .OP_HAS_END               (OP_HAS_END),
        .OP_END                   (OP_END),
        .OP_WORD                  (OP_WORD),
        .OP_BIT                   (OP_BIT),
        .LATCH_IMG                (LATCH_IMG),
        .WORD_MEM                 (WORD_MEM),
        .OUT_IMG                  (OUT_IMG),
        .PAUSE_RUNG               (PAUSE_RUNG),
        .PAUSE_START              (PAUSE_START),
        .PAUSE_END                (PAUSE_END),
        .PHYS_OUT                 (PHYS_OUT)
    );
    selog_outmod u_out (.clk(CLK), .drive(PHYS_OUT), .field(field));
    always #10 CLK = ~CLK;
    task step;
        @(posedge CLK);
        #1;
    endtask
    task chk(input string n, input logic [63:0] e, s);
        n_tests++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task scan(input logic [IMG_W-1:0] v);
        IMG_IN = v;
        SCAN_TICK = 1'h1;
        step;
        SCAN_TICK = 1'h0;
        // Idle edge so a following call never re-raises the tick at once
        step;
    endtask
    task op(input selog_op_t c, input logic [IDX_W-1:0] s, e,
            input logic h, r);
        OP_CODE = c;
        OP_START = s;
        OP_END = e;
        OP_HAS_END = h;
        OP_RUNG = r;
        OP_VALID = 1'h1;
        step;
        OP_VALID = 1'h0;
        step;
    endtask
    task t_edges;
        RUNG_IN = 1'h1;
        scan(64'h8);
        chk("first", 1'h0, AND_RISING_EDGE_CONTACT);
        scan(64'h0);
        chk("fall", 1'h1, AND_FALLING_EDGE_CONTACT);
        RUNG_IN = 1'h0;
        step;
        chk("or", 1'h1, OR_FALLING_EDGE_CONTACT);
        scan(64'h0);
        chk("once", 1'h0, OR_FALLING_EDGE_CONTACT);
        scan(64'h8);
        chk("and", 1'h0, AND_RISING_EDGE_CONTACT);
        RUNG_IN = 1'h1;
        step;
        chk("rise", 1'h1, AND_RISING_EDGE_CONTACT);
        SYS_RST = 1'h1;
        step;
        SYS_RST = 1'h0;
        scan(64'h0);
        chk("hist", 1'h0, AND_FALLING_EDGE_CONTACT);
        $display("edges done");
    endtask
    task t_latch;
        INPUT_OWNED = 64'h10;
        op(SELOG_OP_SET, 6'h02, 6'h05, 1'h1, 1'h1);
        chk("set", 64'h2c, LATCH_IMG);
        step;
        chk("hold", 64'h2c, LATCH_IMG);
        op(SELOG_OP_RST, 6'h03, 6'h00, 1'h0, 1'h1);
        chk("rst", 64'h24, LATCH_IMG);
        op(SELOG_OP_RST, 6'h02, 6'h05, 1'h1, 1'h0);
        chk("rung", 64'h24, LATCH_IMG);
        $display("latch done");
    endtask
    task t_bits;
        OP_WORD = 4'h2;
        OP_BIT = 5'h0f;
        op(SELOG_OP_BSET, 6'h00, 6'h00, 1'h0, 1'h1);
        chk("bset", 1'h1, WORD_MEM[47]);
        OP_BIT = 5'h10;
        op(SELOG_OP_BCLR, 6'h00, 6'h00, 1'h0, 1'h1);
        chk("bsel", 1'h1, WORD_MEM[47]);
        OP_BIT = 5'h0e;
        op(SELOG_OP_BSET, 6'h00, 6'h00, 1'h0, 1'h1);
        OP_BIT = 5'h0f;
        op(SELOG_OP_BCLR, 6'h00, 6'h00, 1'h0, 1'h1);
        chk("bclr", 64'h4000, WORD_MEM[47:32]);
        $display("bits done");
    endtask
    task t_pause;
        OUT_IMG = 32'hffffffff;
        {PAUSE_START, PAUSE_END, PAUSE_RUNG} = {5'h08, 5'h0f, 1'h1};
        scan(64'h0);
        chk("pause", 64'hffff00ff, PHYS_OUT);
        chk("dark", 64'hffff00ff, field);
        OUT_IMG = 32'h0f0f0f0f;
        scan(64'h0);
        chk("image", 64'h0f0f000f, PHYS_OUT);
        PAUSE_RUNG = 1'h0;
        scan(64'h0);
        chk("resume", 64'h0f0f0f0f, PHYS_OUT);
        step;
        chk("field", 64'h0f0f0f0f, field);
        $display("pause done");
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) step;
        SYS_RST = 1'h0;
        t_edges;
        t_latch;
        t_bits;
        t_pause;
        results;
    end
endmodule
bind selog_top selog_chk u_chk (
    .CLK                      (CLK),
    .SYS_RST                  (SYS_RST),
    .SCAN_TICK                (SCAN_TICK),
    .RUNG_IN                  (RUNG_IN),
    .EDGE_IDX                 (EDGE_IDX),
    .OR_FALLING_EDGE_CONTACT  (OR_FALLING_EDGE_CONTACT),
    .AND_RISING_EDGE_CONTACT  (AND_RISING_EDGE_CONTACT),
    .AND_FALLING_EDGE_CONTACT (AND_FALLING_EDGE_CONTACT),
    .OP_VALID                 (OP_VALID),
    .OP_RUNG                  (OP_RUNG),
    .OP_CODE                  (OP_CODE),
    .INPUT_OWNED              (INPUT_OWNED),
    .LATCH_IMG                (LATCH_IMG),
    .PAUSE_RUNG               (PAUSE_RUNG),
    .OUT_IMG                  (OUT_IMG),
    .PHYS_OUT                 (PHYS_OUT)
);
